// file: verilog/scc_pkg.sv
/*
  Constants for the strap capture and configuration identity block.
  Assumes an 8-bit register read port with the printed offsets as addresses.
*/
package scc_pkg;
  // Register offsets as printed
  localparam logic [7:0] SCC_OFS_HARD_STRAP = 8'h09;
  localparam logic [7:0] SCC_OFS_TARGET_ADDR = 8'h0A;
  localparam logic [7:0] SCC_OFS_IMAGE_REV = 8'h0B;
  // Values after reset
  localparam logic [6:0] SCC_ADDR_RESET = 7'h54;
  localparam logic [7:0] SCC_REV_RESET = 8'h00;
  localparam logic [5:0] SCC_CODE_RESET = 6'h00;
  localparam logic [7:0] SCC_RDATA_RESET = 8'h00;
  // Field positions
  localparam int SCC_CODE_LSB = 2;
  localparam int SCC_ADDR_LSB = 1;
  localparam int SCC_ADDR_MSB_LSB = 2;
  // Low address bits from the three-level strap, and the value forced in hard mode
  localparam logic [1:0] SCC_LOW_PIN_LOW = 2'h0;
  localparam logic [1:0] SCC_LOW_PIN_MID = 2'h1;
  localparam logic [1:0] SCC_LOW_PIN_HIGH = 2'h3;
  localparam logic [1:0] SCC_LOW_FORCED = 2'h0;
  // Strap mode encodings and capture phase states
  localparam logic SCC_MODE_SOFT = 1'b0;
  localparam logic SCC_MODE_HARD = 1'b1;
  typedef enum logic [0:0] {
    SCC_WAIT_RELEASE = 1'b0,
    SCC_RUN = 1'b1
  } scc_phase_type;
endpackage

// file: verilog/scc_strap_capture.sv
/*
  Strap capture and configuration identity registers: hard strap code,
  bus target address and image revision, all read-only.
  Assumes strap pins are stable around reset release and that the
  nonvolatile image outputs are valid whenever reset is low.
*/
//
// Overview of operation
// R1: Latch straps at reset release, hold until reset
// R2: Hard mode: six pins appear in bits 7:2
// R3: Soft mode: hard strap field reads zero
// R4: Target address in bits 7:1, default 0x54
// R5: Soft mode: three-level pin sets low bits
// R6: Hard mode: low two address bits zero
// R7: Upper address bits change only via volatile copy
// R8: Reload revision after reset and each commit
// R9: Mode pin sampled at reset, 1 means hard
// R10: Reserved bits zero, register writes ignored
module scc_strap_capture
  import scc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Board straps
  input wire logic strap_mode_select,
  input wire logic [5:0] strap_code_pins,
  input wire logic addr_strap_high,
  input wire logic mid_level_input,
  // Nonvolatile image
  input wire logic [6:0] nv_target_address,
  input wire logic [7:0] nv_image_revision,
  input wire logic nv_commit_done,
  // Volatile configuration copy
  input wire logic cfg_addr_wr,
  input wire logic [4:0] cfg_addr_msb,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Captured configuration
  output logic [6:0] target_address,
  output logic hard_mode
);

  scc_phase_type phase;
  logic [5:0] hard_strap_code;
  logic [7:0] image_revision_field;
  logic [1:0] next_low_bits;
  logic [7:0] next_rdata;

  // Straps cannot be taken under the asynchronous reset itself, so the
  // first clock after release does the capture.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= SCC_WAIT_RELEASE;
    end else begin
      phase <= SCC_RUN;
    end
  end

  // Mode pin is read once; later moves on the pin are ignored until reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hard_mode <= SCC_MODE_SOFT;
    end else if (phase == SCC_WAIT_RELEASE) begin
      hard_mode <= strap_mode_select; // R9 R1
    end
  end

  // Stored already zeroed in soft mode, so the read path needs no mode test
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hard_strap_code <= SCC_CODE_RESET;
    end else if (phase == SCC_WAIT_RELEASE) begin
      if (strap_mode_select == SCC_MODE_HARD) begin
        hard_strap_code <= strap_code_pins; // R2 R1
      end else begin
        hard_strap_code <= SCC_CODE_RESET; // R3
      end
    end
  end

  // Mid level wins over the high/low reading of the same pin
  always_comb begin
    if (strap_mode_select == SCC_MODE_HARD) begin
      next_low_bits = SCC_LOW_FORCED; // R6
    end else if (mid_level_input) begin
      next_low_bits = SCC_LOW_PIN_MID; // R5
    end else if (addr_strap_high) begin
      next_low_bits = SCC_LOW_PIN_HIGH; // R5
    end else begin
      next_low_bits = SCC_LOW_PIN_LOW; // R5
    end
  end

  // Register writes never reach this; only the volatile copy does, and it
  // touches the upper five bits only, so the strapped low bits survive it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      target_address <= SCC_ADDR_RESET;
    end else if (phase == SCC_WAIT_RELEASE) begin
      target_address <= {nv_target_address[6:2], next_low_bits}; // R4 R5 R6 R1
    end else if (cfg_addr_wr) begin
      target_address[6:2] <= cfg_addr_msb; // R7
    end
  end

  // A commit on the capture edge reloads the same image, so no priority is needed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      image_revision_field <= SCC_REV_RESET;
    end else if (phase == SCC_WAIT_RELEASE || nv_commit_done) begin
      image_revision_field <= nv_image_revision; // R8
    end
  end

  // Reads answer one cycle later; unmapped offsets read zero
  always_comb begin
    next_rdata = SCC_RDATA_RESET;
    unique case (reg_addr)
      SCC_OFS_HARD_STRAP: next_rdata = {hard_strap_code, 2'h0}; // R2 R3 R10
      SCC_OFS_TARGET_ADDR: next_rdata = {target_address, 1'h0}; // R4 R10
      SCC_OFS_IMAGE_REV: next_rdata = image_revision_field; // R8
      default: next_rdata = SCC_RDATA_RESET; // R10
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rvalid <= 1'b0;
      reg_rdata <= SCC_RDATA_RESET;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata <= reg_rd ? next_rdata : SCC_RDATA_RESET;
    end
  end

  default clocking scc_cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // The capture edge itself changes the held values, so checks on holding
  // start from the edge after it.
  a_code_held_stable: assert property (phase == SCC_RUN |=> $stable(hard_strap_code) && $stable(hard_mode)) // R1
    else $error("strap capture changed after release");
  a_hard_code_capture: assert property (phase == SCC_WAIT_RELEASE && strap_mode_select // R2
      |=> hard_strap_code == $past(strap_code_pins) ##1 hard_strap_code == $past(strap_code_pins, 2))
    else $error("hard strap code does not match pins");
  a_soft_code_zero: assert property (reg_rd && reg_addr == SCC_OFS_HARD_STRAP && !hard_mode && phase == SCC_RUN // R3
      |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("soft mode hard strap read not zero");
  a_addr_nv_load: assert property (phase == SCC_WAIT_RELEASE // R4
      |=> target_address[6:2] == $past(nv_target_address[6:2]))
    else $error("target address not loaded from image");
  a_low_bits_mid: assert property (phase == SCC_WAIT_RELEASE && !strap_mode_select && mid_level_input // R5
      |=> target_address[1:0] == 2'h1)
    else $error("mid level strap did not give one");
  a_low_bits_high: assert property (phase == SCC_WAIT_RELEASE && !strap_mode_select && !mid_level_input // R5
      && addr_strap_high |=> target_address[1:0] == 2'h3)
    else $error("high strap did not give three");
  a_hard_low_zero: assert property (phase == SCC_RUN && hard_mode |-> target_address[1:0] == 2'h0) // R6
    else $error("hard mode low address bits not zero");
  a_addr_only_cfg: assert property (phase == SCC_RUN && !cfg_addr_wr |=> $stable(target_address)) // R7
    else $error("target address changed without volatile write");
  a_addr_cfg_write: assert property (phase == SCC_RUN && cfg_addr_wr // R7
      |=> target_address[6:2] == $past(cfg_addr_msb) && $stable(target_address[1:0]))
    else $error("volatile write not applied");
  a_rev_commit: assert property (phase == SCC_RUN && nv_commit_done // R8
      ##1 (reg_rd && reg_addr == SCC_OFS_IMAGE_REV) |=> reg_rdata == $past(nv_image_revision, 2))
    else $error("revision not reloaded on commit");
  a_rev_hold: assert property (phase == SCC_RUN && !nv_commit_done |=> $stable(image_revision_field)) // R8
    else $error("revision changed without commit");
  a_mode_latch: assert property (phase == SCC_WAIT_RELEASE |=> hard_mode == $past(strap_mode_select)) // R9
    else $error("mode select not latched");
  a_write_ignored: assert property (reg_wr && !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00) // R10
    else $error("register write produced an answer");
  a_reserved_zero: assert property (reg_rd && reg_addr == SCC_OFS_TARGET_ADDR // R10
      |=> reg_rdata[0] == 1'b0 && reg_rdata[7:1] == $past(target_address))
    else $error("address read wrong or reserved bit set");
  a_unmapped_zero: assert property (reg_rd && reg_addr != SCC_OFS_HARD_STRAP && reg_addr != SCC_OFS_TARGET_ADDR // R10
      && reg_addr != SCC_OFS_IMAGE_REV |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_low_bits_low: assert property (phase == SCC_WAIT_RELEASE && !strap_mode_select && !mid_level_input // R5
      && !addr_strap_high |=> target_address[1:0] == 2'h0)
    else $error("low strap did not give zero");
  a_hard_low_capture: assert property (phase == SCC_WAIT_RELEASE && strap_mode_select // R6
      |=> target_address[1:0] == 2'h0)
    else $error("hard mode capture kept strap low bits");
  a_soft_code_held: assert property (phase == SCC_RUN && !hard_mode |-> hard_strap_code == 6'h00) // R3
    else $error("soft mode hard strap code not zero");
  a_low_bits_hold: assert property (phase == SCC_RUN |=> $stable(target_address[1:0])) // R1
    else $error("strap low address bits changed after release");
  a_rev_reset_load: assert property (phase == SCC_WAIT_RELEASE // R8
      |=> image_revision_field == $past(nv_image_revision))
    else $error("revision not loaded after reset");
  a_rev_commit_load: assert property (phase == SCC_RUN && nv_commit_done // R8
      |=> image_revision_field == $past(nv_image_revision))
    else $error("revision not loaded on commit");

  // Register port: one answer a cycle after each read, zero data otherwise
  a_hard_read: assert property (reg_rd && reg_addr == SCC_OFS_HARD_STRAP // R2
      |=> reg_rvalid && reg_rdata == {$past(hard_strap_code), 2'h0})
    else $error("hard strap read wrong");
  a_rev_read: assert property (reg_rd && reg_addr == SCC_OFS_IMAGE_REV // R8
      |=> reg_rvalid && reg_rdata == $past(image_revision_field))
    else $error("revision read wrong");
  a_read_answer: assert property (reg_rd |=> reg_rvalid) // R10
    else $error("read got no answer");
  a_idle_data_zero: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00) // R10
    else $error("read data stood without a read");
  a_wr_keeps_code: assert property (phase == SCC_RUN && reg_wr |=> $stable(hard_strap_code) && $stable(hard_mode)) // R10
    else $error("register write changed captured straps");

  // Scenarios the bench is meant to reach
  c_hard_read: cover property (hard_mode && reg_rd && reg_addr == SCC_OFS_HARD_STRAP ##1 reg_rdata != 8'h00);
  c_soft_mid: cover property (phase == SCC_RUN && !hard_mode && target_address[1:0] == 2'h1);
  c_soft_high: cover property (phase == SCC_RUN && !hard_mode && target_address[1:0] == 2'h3);
  c_commit: cover property (phase == SCC_RUN && nv_commit_done ##1 reg_rd && reg_addr == SCC_OFS_IMAGE_REV);
  c_cfg_write: cover property (phase == SCC_RUN && cfg_addr_wr && reg_wr);

endmodule

// file: sim/scc_board_model.sv
/*
  Board side of the three-level address strap.
  Assumes the bench picks the level: 0 low, 1 mid, 2 high.
*/
module scc_board_model (
  // Requested level
  input wire logic [1:0] level,
  // Pin as seen by the device
  output logic addr_strap_high,
  output logic mid_level_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mid level reads as not high, so a broken mid-over-high priority would not show up
  assign mid_level_input = (level == 2'h1);
  assign addr_strap_high = (level == 2'h2);
endmodule

// file: sim/scc_strap_capture_tb.sv
/*
  Self-checking bench for the strap capture registers.
  Assumes one 40 MHz clock and inputs driven 2 ns after each rising edge.
*/
module scc_strap_capture_tb
  import scc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, mode = 0, addr_wr = 0, commit = 0, reg_rd = 0, reg_wr = 0, rvalid, hard, ah, mid;
  logic [1:0] level = 0;
  logic [1:0] lows [3] = '{2'h0, 2'h1, 2'h3};
  logic [5:0] pins = 0;
  logic [6:0] nv_addr = 7'h54, taddr;
  logic [4:0] msb = 0;
  logic [7:0] rev = 0, reg_addr = 0, wdata = 0, rdata;
  int miscompares = 0, tests_run = 0, cycles = 0;
  scc_board_model board (.level(level), .addr_strap_high(ah), .mid_level_input(mid));
  scc_strap_capture dut (.clock(clock), .rst(rst), .strap_mode_select(mode), .strap_code_pins(pins),
    .addr_strap_high(ah), .mid_level_input(mid), .nv_target_address(nv_addr), .nv_image_revision(rev),
    .nv_commit_done(commit), .cfg_addr_wr(addr_wr), .cfg_addr_msb(msb), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .target_address(taddr), .hard_mode(hard));
  initial begin
    forever #12.5 clock = ~clock;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Answer is looked at in the one cycle it stands, then must drop to idle
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1;
    @(posedge clock);
    #2 reg_rd = 0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
    @(posedge clock);
    #2 chk({7'h00, rvalid}, 8'h00);
    chk(rdata, 8'h00);
  endtask
  task boot(input logic m, input logic [5:0] p, input logic [1:0] l);
    rst = 1;
    mode = m;
    pins = p;
    level = l;
    repeat (16) @(posedge clock);
    #1 chk({1'b0, taddr}, 8'h54);
    #1 rst = 0;
    @(posedge clock);
    #2;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    #2;
    nv_addr = 7'h2A;
    rev = 8'h5C;
    boot(SCC_MODE_HARD, 6'h2D, 2'h1);
    chk({7'h00, hard}, 8'h01);
    chk({1'b0, taddr}, 8'h28);
    rd(SCC_OFS_HARD_STRAP, 8'hB4);
    rd(SCC_OFS_TARGET_ADDR, 8'h50);
    rd(SCC_OFS_IMAGE_REV, 8'h5C);
    // Straps move after capture and a write is attempted
    pins = 6'h00;
    mode = 0;
    level = 2'h2;
    reg_wr = 1;
    wdata = 8'hFF;
    reg_addr = SCC_OFS_HARD_STRAP;
    @(posedge clock);
    #2 reg_wr = 0;
    rd(SCC_OFS_HARD_STRAP, 8'hB4);
    rd(SCC_OFS_TARGET_ADDR, 8'h50);
    rd(8'h0C, 8'h00);
    nv_addr = 7'h54;
    for (int i = 0; i < 3; i++) begin
      boot(SCC_MODE_SOFT, 6'h3F, i[1:0]);
      chk({7'h00, hard}, 8'h00);
      rd(SCC_OFS_HARD_STRAP, 8'h00);
      rd(SCC_OFS_TARGET_ADDR, {5'h15, lows[i], 1'b0});
    end
    msb = 5'h0B;
    addr_wr = 1;
    @(posedge clock);
    #2 addr_wr = 0;
    chk({1'b0, taddr}, 8'h2F);
    rd(SCC_OFS_TARGET_ADDR, 8'h5E);
    rev = 8'hC3;
    rd(SCC_OFS_IMAGE_REV, 8'h5C);
    commit = 1;
    @(posedge clock);
    #2 commit = 0;
    rd(SCC_OFS_IMAGE_REV, 8'hC3);
    finish_test;
  end
endmodule
